// [design/rlp_pkg.sv]
package rlp_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1_000_000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // sizes
  localparam int NUM_LINES  = 8;
  localparam int MAX_PEERS  = 40;
  localparam int IDX_W      = 6;
  localparam logic [2:0] MISS_LAST = 3'h7;  // eighth consecutive miss

  // times in milliseconds, counted on the tick; the transmit burst in clock cycles
  localparam logic [14:0] BOND_HOLD_MS    = 15'h07D0;  // 2000
  localparam logic [14:0] SEARCH_MS       = 15'h7530;  // 30000
  localparam logic [14:0] FOUND_MS        = 15'h0BB8;  // 3000
  localparam logic [14:0] FULL_MS         = 15'h2710;  // 10000
  localparam logic [6:0]  REPLY_HOLD_MS   = 7'h64;     // 100
  localparam logic [9:0]  SEARCH_ON_MS    = 10'h064;   // 100
  localparam logic [9:0]  SEARCH_OFF_MS   = 10'h384;   // 900
  localparam logic [9:0]  FOUND_ON_MS     = 10'h190;   // 400
  localparam logic [9:0]  FOUND_OFF_MS    = 10'h064;   // 100
  localparam logic [9:0]  FULL_ON_MS      = 10'h064;   // 100
  localparam logic [9:0]  FULL_OFF_MS     = 10'h064;   // 100
  localparam logic [5:0]  PAIR_SLOT_MS    = 6'h32;     // 50
  localparam logic [3:0]  CTRL_PERIOD_MS  = 4'hD;      // 13
  localparam logic [4:0]  TX_BURST_CYC    = 5'h10;     // 16 cycles

  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DIR_MASK  = 8'h04;
  localparam logic [7:0] REG_ANALOG    = 8'h08;
  localparam logic [7:0] REG_PAYLOAD   = 8'h0C;
  localparam logic [7:0] REG_LOCAL     = 8'h10;
  localparam logic [7:0] REG_CMD       = 8'h14;
  localparam logic [7:0] REG_PERM      = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1C;
  localparam logic [7:0] REG_HOST_DATA = 8'h20;
  localparam logic [7:0] REG_PEER      = 8'h24;

  // control bits
  localparam int CTRL_SERIAL_SRC = 0;
  localparam int CTRL_PAYLOAD_EN = 1;
  localparam int CTRL_SAMPLE_A   = 2;
  localparam int CTRL_SAMPLE_B   = 3;
  // command bits
  localparam int CMD_PAIR        = 0;
  localparam int CMD_CANCEL      = 1;
  localparam int CMD_SAMPLE_REQ  = 2;
  localparam int CMD_SEND_CTRL   = 3;

  localparam logic [7:0]  FULL_MASK   = 8'hFF;
  localparam logic [31:0] DEFAULT_ADR = 32'h0000_0001;  // arbitrary value

  // packet kinds on the radio side
  typedef enum logic [1:0] {
    PK_CTRL   = 2'h0,
    PK_ACK    = 2'h1,
    PK_SAMPLE = 2'h2,
    PK_PAIR   = 2'h3
  } rlp_kind_t;

  typedef struct packed {
    rlp_kind_t   kind;
    logic [31:0] src_addr;   // sender's local address
    logic [31:0] echo_addr;  // acknowledged sender, for acknowledgements
    logic [7:0]  status;     // line states
    logic [15:0] data;       // attached bytes
  } rlp_pkt_t;

  // pairing states
  typedef enum logic [3:0] {
    P_IDLE   = 4'b0001,
    P_SEARCH = 4'b0010,
    P_FOUND  = 4'b0100,
    P_FULL   = 4'b1000
  } rlp_pair_t;

endpackage

// [design/rlp_top.sv]
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rlp_top
  import rlp_pkg::*;
#(
  parameter int          TICK_CYC   = TICK_CYCLES,
  parameter logic [31:0] LOCAL_ADDR = DEFAULT_ADR
)(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_q,
  input  wire logic        rx_pkt_valid,
  input  wire rlp_pkt_t    rx_pkt,
  input  wire logic        rx_slot_miss,
  output logic             tx_pkt_valid_q,
  output rlp_pkt_t         tx_pkt_q,
  output logic             hop_lock_q,
  output logic [31:0]      hop_seed_q,
  input  wire logic [7:0]  remote_lines_in,
  output logic [7:0]       remote_lines_out_q,
  output logic [7:0]       remote_lines_oe_q,
  input  wire logic        low_group_direction,
  input  wire logic        high_group_direction,
  input  wire logic        bond_request,
  input  wire logic        reply_permit,
  input  wire logic [7:0]  analog_a,
  input  wire logic [7:0]  analog_b,
  output logic             reply_seen_q,
  output logic             activity_indicator_q,
  output logic             tx_amp_enable_q,
  output logic             rx_amp_enable_q
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // count of set bits in a nibble
  function automatic logic [2:0] ones4(input logic [3:0] v);
    ones4 = 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick divider
  logic [31:0] div_q, div_d;  // cycle count within a tick
  logic        tick_q, tick_d; // one-cycle pulse per millisecond

  // wrap the divider at the tick period
  always_comb
  begin
    tick_d = (div_q == 32'(TICK_CYC - 1));
    div_d  = tick_d ? 32'h0 : div_q + 32'h1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [3:0]  ctrl_q, ctrl_d;       // control source, payload, sample picks
  logic [7:0]  dir_mask_q, dir_mask_d; // 1 = input, serial source
  logic [3:0]  analog_q, analog_d;   // analog picks on lines 4..7
  logic [15:0] payload_q, payload_d; // preset acknowledgement bytes
  logic [31:0] local_q, local_d;     // own address
  logic        cmd_wr;               // command register written
  logic        perm_wr;              // permission register written
  logic [7:0]  dir_eff;              // effective direction, 1 = input
  logic [7:0]  analog_lines;         // analog lines as a byte

  // register writes; an analog pick of more than two lines is refused
  always_comb
  begin
    ctrl_d     = ctrl_q;
    dir_mask_d = dir_mask_q;
    analog_d   = analog_q;
    payload_d  = payload_q;
    local_d    = local_q;
    cmd_wr     = reg_wr && (reg_addr == REG_CMD);
    perm_wr    = reg_wr && (reg_addr == REG_PERM);
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:     ctrl_d     = reg_wdata[3:0];
        REG_DIR_MASK: dir_mask_d = reg_wdata[7:0];
        REG_ANALOG:
        begin
          if (ones4(reg_wdata[7:4]) <= 3'h2)
            analog_d = reg_wdata[7:4];
        end
        REG_PAYLOAD:  payload_d  = reg_wdata[15:0];
        REG_LOCAL:    local_d    = reg_wdata;
        default:      ;
      endcase
    end
    analog_lines = {analog_q, 4'h0};
    // serial source takes the per-line mask, else the two group pins
    if (ctrl_q[CTRL_SERIAL_SRC])
      dir_eff = dir_mask_q;
    else
      dir_eff = {{4{high_group_direction}}, {4{low_group_direction}}};
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q     <= 4'h0;
      dir_mask_q <= 8'h00;
      analog_q   <= 4'h0;
      payload_q  <= 16'h0000;
      local_q    <= DEFAULT_ADR;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      dir_mask_q <= dir_mask_d;
      analog_q   <= analog_d;
      payload_q  <= payload_d;
      local_q    <= (local_q == DEFAULT_ADR && local_d == DEFAULT_ADR) ? LOCAL_ADDR : local_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // paired list and pairing sequence
  logic [31:0]      peer_addr_q [MAX_PEERS];
  logic [7:0]       peer_mask_q [MAX_PEERS];
  logic [31:0]      peer_addr_d [MAX_PEERS];
  logic [7:0]       peer_mask_d [MAX_PEERS];
  logic [IDX_W-1:0] count_q, count_d;   // entries in use
  logic             rx_hit;             // sender is in the list
  logic [IDX_W-1:0] rx_idx;             // its entry
  rlp_pair_t        pst_q, pst_d;       // pairing state
  logic [14:0]      ptmr_q, ptmr_d;     // pairing timer, ms
  logic [14:0]      hold_q, hold_d;     // bond high time, ms
  logic             held_q, held_d;     // sustained hold seen
  logic             bond_prev_q;        // last bond level
  logic [5:0]       slot_q, slot_d;     // search slot timer, ms
  logic             tx_phase_q, tx_phase_d; // search transmit half
  logic             pair_tx;            // send a search packet
  logic             bond_rise;
  logic             table_full;
  logic             contact;            // another searcher heard

  // search the list; the lowest matching entry wins
  always_comb
  begin
    rx_hit = 1'b0;
    rx_idx = '0;
    for (int i = MAX_PEERS - 1; i >= 0; i--)
    begin
      if ((IDX_W'(i) < count_q) && (peer_addr_q[i] == rx_pkt.src_addr))
      begin
        rx_hit = 1'b1;
        rx_idx = IDX_W'(i);
      end
    end
  end

  // pairing sequence and list updates
  always_comb
  begin
    peer_addr_d = peer_addr_q;
    peer_mask_d = peer_mask_q;
    count_d     = count_q;
    pst_d       = pst_q;
    ptmr_d      = ptmr_q;
    held_d      = held_q;
    slot_d      = slot_q;
    tx_phase_d  = tx_phase_q;
    pair_tx     = 1'b0;
    bond_rise   = bond_request && !bond_prev_q;
    table_full  = (count_q == IDX_W'(MAX_PEERS));
    contact     = rx_pkt_valid && (rx_pkt.kind == PK_PAIR);
    // the high time counts ticks while the pin is high; clearing it while low
    // keeps an old long hold from ending a later serially started search
    if (bond_rise || !bond_request)
      hold_d = 15'h0;
    else if (bond_request && tick_q && hold_q < BOND_HOLD_MS)
      hold_d = hold_q + 15'h1;
    else
      hold_d = hold_q;
    if (tick_q && pst_q != P_IDLE)
      ptmr_d = ptmr_q + 15'h1;
    case (pst_q)
      P_IDLE:
      begin
        if (bond_rise || (cmd_wr && reg_wdata[CMD_PAIR]))
        begin
          ptmr_d = 15'h0;
          held_d = 1'b0;
          slot_d = 6'h0;
          tx_phase_d = 1'b1;
          pst_d = table_full ? P_FULL : P_SEARCH;
        end
      end
      P_SEARCH:
      begin
        if (hold_q >= BOND_HOLD_MS)
          held_d = 1'b1;
        // alternate between sending and listening
        if (tick_q)
        begin
          slot_d = (slot_q == PAIR_SLOT_MS - 6'h1) ? 6'h0 : slot_q + 6'h1;
          if (slot_q == PAIR_SLOT_MS - 6'h1)
            tx_phase_d = !tx_phase_q;
        end
        pair_tx = tx_phase_q && tick_q && (slot_q == 6'h0);
        if (bond_rise || (cmd_wr && reg_wdata[CMD_CANCEL]))
          pst_d = P_IDLE;
        else if (contact && !table_full)
        begin
          pair_tx = 1'b1; // answer so the other side completes too
          ptmr_d = 15'h0;
          pst_d = P_FOUND;
          if (rx_hit)
            peer_mask_d[rx_idx] = FULL_MASK;
          else
          begin
            peer_addr_d[count_q] = rx_pkt.src_addr;
            peer_mask_d[count_q] = FULL_MASK;
            count_d = count_q + IDX_W'(1);
          end
        end
        else if (!bond_request && (held_q || ptmr_q >= SEARCH_MS))
          pst_d = P_IDLE;
      end
      P_FOUND:
      begin
        if (ptmr_q >= FOUND_MS && !bond_request)
          pst_d = P_IDLE;
      end
      P_FULL:
      begin
        if (ptmr_q >= FULL_MS)
          pst_d = P_IDLE;
      end
      default: pst_d = P_IDLE;
    endcase
    // software may narrow a partner's mask afterwards
    if (perm_wr && reg_wdata[5:0] < count_q)
      peer_mask_d[reg_wdata[5:0]] = reg_wdata[15:8];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < MAX_PEERS; i++)
      begin
        peer_addr_q[i] <= 32'h0;
        peer_mask_q[i] <= 8'h00;
      end
      count_q     <= '0;
      pst_q       <= P_IDLE;
      ptmr_q      <= 15'h0;
      hold_q      <= 15'h0;
      held_q      <= 1'b0;
      bond_prev_q <= 1'b0;
      slot_q      <= 6'h0;
      tx_phase_q  <= 1'b0;
    end
    else
    begin
      peer_addr_q <= peer_addr_d;
      peer_mask_q <= peer_mask_d;
      count_q     <= count_d;
      pst_q       <= pst_d;
      ptmr_q      <= ptmr_d;
      hold_q      <= hold_d;
      held_q      <= held_d;
      bond_prev_q <= bond_request;
      slot_q      <= slot_d;
      tx_phase_q  <= tx_phase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link: responding and initiating roles
  logic [2:0]  miss_q, miss_d;        // consecutive misses while locked
  logic [7:0]  lines_d, oe_d;
  logic [6:0]  rtmr_q, rtmr_d;        // reply-seen hold, ms
  logic [7:0]  last_status_q, last_status_d;
  logic        sent_q, sent_d;        // a control packet has gone out
  logic [3:0]  ctmr_q, ctmr_d;        // control repeat timer, ms
  logic [15:0] host_q, host_d;        // bytes for the host
  logic        host_new_q, host_new_d;
  logic        lock_d;
  logic [31:0] seed_d;
  logic        tx_v_d;
  rlp_pkt_t    tx_d;
  logic        ctrl_ok, samp_ok, ack_ok;
  logic [7:0]  in_lines;              // digital input lines
  logic [15:0] samp_data;

  always_comb
  begin
    miss_d        = miss_q;
    lock_d        = hop_lock_q;
    seed_d        = hop_seed_q;
    rtmr_d        = rtmr_q;
    last_status_d = last_status_q;
    sent_d        = sent_q;
    ctmr_d        = ctmr_q;
    host_d        = host_q;
    host_new_d    = host_new_q;
    tx_v_d        = 1'b0;
    tx_d          = '{kind: PK_CTRL, src_addr: local_q, echo_addr: 32'h0,
                      status: 8'h00, data: 16'h0000};
    oe_d          = ~dir_eff & ~analog_lines;
    lines_d       = remote_lines_out_q & oe_d;
    in_lines      = remote_lines_in & dir_eff & ~analog_lines;
    samp_data     = {ctrl_q[CTRL_SAMPLE_B] ? analog_b : 8'h00,
                     ctrl_q[CTRL_SAMPLE_A] ? analog_a : 8'h00};
    // unpaired or foreign senders are dropped while locked
    ctrl_ok = rx_pkt_valid && rx_pkt.kind == PK_CTRL && rx_hit
              && (!hop_lock_q || rx_pkt.src_addr == hop_seed_q);
    samp_ok = rx_pkt_valid && rx_pkt.kind == PK_SAMPLE && rx_hit
              && (!hop_lock_q || rx_pkt.src_addr == hop_seed_q);
    ack_ok  = rx_pkt_valid && rx_pkt.kind == PK_ACK && sent_q
              && rx_pkt.echo_addr == local_q && rx_pkt.status == last_status_q;
    if (ctrl_ok)
    begin
      lock_d = 1'b1;
      seed_d = rx_pkt.src_addr;
      miss_d = 3'h0;
      for (int i = 0; i < NUM_LINES; i++)
      begin
        if (oe_d[i] && peer_mask_q[rx_idx][i])
          lines_d[i] = rx_pkt.status[i];
      end
      if (reply_permit)
      begin
        tx_v_d = 1'b1;
        tx_d.kind = PK_ACK;
        tx_d.echo_addr = rx_pkt.src_addr;
        tx_d.status = rx_pkt.status;
        tx_d.data = ctrl_q[CTRL_PAYLOAD_EN] ? payload_q : 16'h0000;
      end
    end
    else if (hop_lock_q && rx_slot_miss)
    begin
      miss_d = miss_q + 3'h1;
      if (miss_q == MISS_LAST)
        lock_d = 1'b0;
    end
    if (samp_ok && !ctrl_ok)
    begin
      tx_v_d = 1'b1;
      tx_d.kind = PK_ACK;
      tx_d.echo_addr = rx_pkt.src_addr;
      tx_d.status = rx_pkt.status;
      tx_d.data = samp_data;
    end
    // initiator: matching acknowledgements restart the hold
    if (ack_ok)
    begin
      rtmr_d = REPLY_HOLD_MS;
      host_d = rx_pkt.data;
      host_new_d = 1'b1;
    end
    else if (tick_q && rtmr_q != 7'h0)
      rtmr_d = rtmr_q - 7'h1;
    if (!ack_ok && reg_rd && reg_addr == REG_HOST_DATA)
      host_new_d = 1'b0;
    if (tick_q)
      ctmr_d = (ctmr_q == 4'h0) ? 4'h0 : ctmr_q - 4'h1;
    // lower-priority sends only when no answer is going out
    if (!tx_v_d)
    begin
      if (pair_tx)
      begin
        tx_v_d = 1'b1;
        tx_d.kind = PK_PAIR;
      end
      else if (cmd_wr && reg_wdata[CMD_SAMPLE_REQ])
      begin
        tx_v_d = 1'b1;
        tx_d.kind = PK_SAMPLE;
      end
      else if ((cmd_wr && reg_wdata[CMD_SEND_CTRL])
               || (in_lines != 8'h00 && ctmr_q == 4'h0 && pst_q == P_IDLE))
      begin
        tx_v_d = 1'b1;
        tx_d.status = (cmd_wr && reg_wdata[CMD_SEND_CTRL]) ? reg_wdata[15:8] : in_lines;
        last_status_d = tx_d.status;
        sent_d = 1'b1;
        ctmr_d = CTRL_PERIOD_MS;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      miss_q             <= 3'h0;
      hop_lock_q         <= 1'b0;
      hop_seed_q         <= 32'h0;
      rtmr_q             <= 7'h0;
      reply_seen_q       <= 1'b0;
      last_status_q      <= 8'h00;
      sent_q             <= 1'b0;
      ctmr_q             <= 4'h0;
      host_q             <= 16'h0000;
      host_new_q         <= 1'b0;
      tx_pkt_valid_q     <= 1'b0;
      tx_pkt_q           <= '0;
      remote_lines_out_q <= 8'h00;
      remote_lines_oe_q  <= 8'h00;
    end
    else
    begin
      miss_q             <= miss_d;
      hop_lock_q         <= lock_d;
      hop_seed_q         <= seed_d;
      rtmr_q             <= rtmr_d;
      reply_seen_q       <= (rtmr_d != 7'h0);
      last_status_q      <= last_status_d;
      sent_q             <= sent_d;
      ctmr_q             <= ctmr_d;
      host_q             <= host_d;
      host_new_q         <= host_new_d;
      tx_pkt_valid_q     <= tx_v_d;
      tx_pkt_q           <= tx_d;
      remote_lines_out_q <= lines_d;
      remote_lines_oe_q  <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator, amplifier enables and read port
  logic [9:0]  pat_q, pat_d;       // position in the blink period, ms
  logic [9:0]  on_ms, period_ms;
  logic [4:0]  burst_q, burst_d;   // transmit window, cycles
  logic        ind_d, txa_d;
  logic [31:0] rdata_d;

  always_comb
  begin
    on_ms     = SEARCH_ON_MS;
    period_ms = SEARCH_ON_MS + SEARCH_OFF_MS;
    case (pst_q)
      P_FOUND:
      begin
        on_ms     = FOUND_ON_MS;
        period_ms = FOUND_ON_MS + FOUND_OFF_MS;
      end
      P_FULL:
      begin
        on_ms     = FULL_ON_MS;
        period_ms = FULL_ON_MS + FULL_OFF_MS;
      end
      default: ;
    endcase
    // restart the pattern whenever the pairing state moves
    if (pst_d != pst_q)
      pat_d = 10'h0;
    else if (tick_q)
      pat_d = (pat_q == period_ms - 10'h1) ? 10'h0 : pat_q + 10'h1;
    else
      pat_d = pat_q;
    if (pst_d == P_IDLE)
      ind_d = lock_d || tx_v_d || burst_q != 5'h0;
    else
      ind_d = (pat_d < on_ms);
    burst_d = tx_v_d ? TX_BURST_CYC : (burst_q == 5'h0 ? 5'h0 : burst_q - 5'h1);
    // the whole transmit half of a search counts as transmit mode
    txa_d = (burst_d != 5'h0) || (pst_d == P_SEARCH && tx_phase_d);
    // read data for the cycle after the strobe; holes read zero
    rdata_d = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:      rdata_d = {28'h0, ctrl_q};
        REG_DIR_MASK:  rdata_d = {24'h0, dir_mask_q};
        REG_ANALOG:    rdata_d = {24'h0, analog_lines};
        REG_PAYLOAD:   rdata_d = {16'h0, payload_q};
        REG_LOCAL:     rdata_d = local_q;
        REG_PERM:      rdata_d = {26'h0, count_q};
        REG_STATUS:    rdata_d = {16'h0, dir_eff, pst_q, reply_seen_q, hop_lock_q,
                                  tx_amp_enable_q, rx_amp_enable_q};
        REG_HOST_DATA: rdata_d = {15'h0, host_new_q, host_q};
        REG_PEER:      rdata_d = hop_seed_q;
        default:       rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat_q                <= 10'h0;
      burst_q              <= 5'h0;
      activity_indicator_q <= 1'b0;
      tx_amp_enable_q      <= 1'b0;
      rx_amp_enable_q      <= 1'b0;
      reg_rdata_q          <= 32'h0;
    end
    else
    begin
      pat_q                <= pat_d;
      burst_q              <= burst_d;
      activity_indicator_q <= ind_d;
      tx_amp_enable_q      <= txa_d;
      rx_amp_enable_q      <= !txa_d;
      reg_rdata_q          <= rdata_d;
    end
  end

endmodule // rlp_top

// [verif/rlp_chk_asserts.sv]
`timescale 1ns/1ps
module rlp_chk
  import rlp_pkg::*;
#(
  parameter logic [31:0] LOCAL_ADDR = DEFAULT_ADR
)(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        rx_pkt_valid,
  input wire rlp_pkt_t    rx_pkt,
  input wire logic        reply_permit,
  input wire logic        low_group_direction,
  input wire logic        high_group_direction,
  input wire logic        tx_pkt_valid_q,
  input wire rlp_pkt_t    tx_pkt_q,
  input wire logic        hop_lock_q,
  input wire logic [31:0] hop_seed_q,
  input wire logic [7:0]  remote_lines_oe_q,
  input wire logic        reply_seen_q,
  input wire logic        tx_amp_enable_q,
  input wire logic        rx_amp_enable_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_ack_permit:
    assert property (tx_pkt_valid_q && tx_pkt_q.kind == PK_ACK
      && $past(rx_pkt.kind == PK_CTRL) |-> $past(reply_permit))
    else $error("ack sent without permit");
  a_ack_echo:
    assert property (tx_pkt_valid_q && tx_pkt_q.kind == PK_ACK
      |-> tx_pkt_q.echo_addr == $past(rx_pkt.src_addr))
    else $error("ack echoes wrong sender");
  a_lock_foreign:
    assert property ($past(hop_lock_q) && tx_pkt_valid_q && tx_pkt_q.kind == PK_ACK
      |-> tx_pkt_q.echo_addr == $past(hop_seed_q))
    else $error("ack to foreign sender while locked");
  a_lock_cause:
    assert property ($rose(hop_lock_q) |-> $past(rx_pkt_valid && rx_pkt.kind == PK_CTRL))
    else $error("lock without control packet");
  a_amp_excl:
    assert property ($past(arst_n) |-> rx_amp_enable_q != tx_amp_enable_q)
    else $error("amplifier enables collide");
  a_amp_tx:
    assert property (tx_pkt_valid_q |-> ##[0:1] tx_amp_enable_q)
    else $error("packet sent without transmit amp");
  a_src_addr:
    assert property (tx_pkt_valid_q |-> tx_pkt_q.src_addr == LOCAL_ADDR)
    else $error("packet lacks local address");
  a_dir_low:
    assert property ($stable(low_group_direction)[*3]
      |-> remote_lines_oe_q[3:0] == {4{~low_group_direction}})
    else $error("low group direction wrong");
  a_dir_high:
    assert property ($stable(high_group_direction)[*3]
      |-> remote_lines_oe_q[7:4] == {4{~high_group_direction}})
    else $error("high group direction wrong");
  a_seen_cause:
    assert property ($rose(reply_seen_q)
      |-> $past(rx_pkt_valid && rx_pkt.kind == PK_ACK && rx_pkt.echo_addr == LOCAL_ADDR))
    else $error("reply seen without matching ack");
endmodule // rlp_chk
bind rlp_top rlp_chk #(.LOCAL_ADDR(LOCAL_ADDR)) u_chk (.*);

// [verif/rlp_peer.sv]
`timescale 1ns/1ps
module rlp_peer
  import rlp_pkg::*;
(
  input  wire logic clk_sys,
  output logic      rx_pkt_valid,
  output rlp_pkt_t  rx_pkt,
  output logic      rx_slot_miss
);
  initial
  begin
    {rx_pkt_valid, rx_pkt, rx_slot_miss} = '0;
  end
  // after a packet the fields are inverted, so stale data never passes for fresh
  task automatic send(input rlp_kind_t k, input logic [31:0] s, ec, input logic [7:0] st);
    @(posedge clk_sys);
    rx_pkt_valid <= 1'b1;
    rx_pkt       <= '{k, s, ec, st, 16'h0};
    @(posedge clk_sys);
    rx_pkt_valid <= 1'b0;
    rx_pkt       <= ~rx_pkt;
  endtask
  // empty hop slots, one pulse each with a gap
  task automatic miss(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      rx_slot_miss <= 1'b1;
      @(posedge clk_sys);
      rx_slot_miss <= 1'b0;
    end
  endtask
endmodule // rlp_peer

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top import rlp_pkg::*;;
  localparam logic [31:0] LOC  = 32'h0000_00A1;  // arbitrary local address
  localparam logic [31:0] PEER = 32'h0000_0B0B;  // arbitrary partner address
  logic        clk_sys, arst_n, reg_wr, reg_rd, rx_pkt_valid, rx_slot_miss, tx_pkt_valid_q;
  logic        hop_lock_q, low_group_direction, high_group_direction, bond_request;
  logic        reply_permit, reply_seen_q, activity_indicator_q, tx_amp_enable_q;
  logic        rx_amp_enable_q;
  logic [7:0]  reg_addr, remote_lines_in, remote_lines_out_q, remote_lines_oe_q;
  logic [7:0]  analog_a, analog_b;
  logic [31:0] reg_wdata, reg_rdata_q, hop_seed_q;
  rlp_pkt_t    rx_pkt, tx_pkt_q;
  logic [31:0] exp_q[$];  // low echo address and data of acknowledgements owed
  int          fails, tests_run;
  rlp_top #(.TICK_CYC(2), .LOCAL_ADDR(LOC)) dut (.*);
  rlp_peer peer (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata_q & m, e);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // every acknowledgement must match the oldest note
  always @(posedge clk_sys)
    if (tx_pkt_valid_q === 1'b1 && tx_pkt_q.kind === PK_ACK)
      check({tx_pkt_q.echo_addr[15:0], tx_pkt_q.data},
            exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h99E5));
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, bond_request} = '0;
    {low_group_direction, high_group_direction, remote_lines_in} = '0;
    reply_permit = 1'b1;
    analog_a = 8'($urandom);
    analog_b = 8'($urandom);
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(REG_PERM, 32'hFF, 32'h0);
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS, 32'hF3, 32'h22);
    check(32'(activity_indicator_q), 32'h1);
    wr(REG_CMD, 32'h2);
    rd(REG_STATUS, 32'hF0, 32'h10);
    wr(REG_CMD, 32'h1);
    peer.send(PK_PAIR, PEER, 32'h0, 8'h00);
    rd(REG_STATUS, 32'hF0, 32'h40);
    rd(REG_PERM, 32'hFF, 32'h1);
    exp_q.push_back({PEER[15:0], 16'h0000});
    peer.send(PK_CTRL, PEER, 32'h0, 8'hA5);
    rd(REG_STATUS, 32'h4, 32'h4);
    check({24'h0, remote_lines_out_q}, 32'hA5);
    wr(REG_PERM, 32'h0F00);  // entry 0 keeps lines 0..3 only
    exp_q.push_back({PEER[15:0], 16'h0000});
    peer.send(PK_CTRL, PEER, 32'h0, 8'hF0);
    @(posedge clk_sys);
    reply_permit <= 1'b0;
    check({24'h0, remote_lines_out_q}, 32'hA0);
    peer.send(PK_CTRL, PEER, 32'h0, 8'h0F);  // permit low: no note
    reply_permit <= 1'b1;
    peer.send(PK_CTRL, 32'h77, 32'h0, 8'h00);  // unpaired sender
    rd(REG_PEER, 32'hFFFF_FFFF, PEER);
    check({24'h0, remote_lines_out_q}, 32'hAF);
    peer.miss(7);
    rd(REG_STATUS, 32'h4, 32'h4);
    peer.miss(1);
    rd(REG_STATUS, 32'h4, 32'h0);
    wr(REG_CMD, 32'h3C08);
    peer.send(PK_ACK, PEER, LOC, 8'h3D);
    rd(REG_STATUS, 32'h8, 32'h0);
    peer.send(PK_ACK, PEER, LOC, 8'h3C);
    rd(REG_STATUS, 32'h8, 32'h8);
    rd(REG_HOST_DATA, 32'h1_FFFF, 32'h1_0000);
    rd(REG_HOST_DATA, 32'h1_0000, 32'h0);
    repeat (180) @(posedge clk_sys);
    rd(REG_STATUS, 32'h8, 32'h8);
    repeat (30) @(posedge clk_sys);
    rd(REG_STATUS, 32'h8, 32'h0);
    @(posedge clk_sys);
    low_group_direction <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({24'h0, remote_lines_oe_q}, 32'hF0);
    // payload on, both analog values in sample answers
    wr(REG_CTRL, 32'hE);
    wr(REG_PAYLOAD, 32'h5A3C);
    exp_q.push_back({PEER[15:0], analog_b, analog_a});
    peer.send(PK_SAMPLE, PEER, 32'h0, 8'h00);
    exp_q.push_back({PEER[15:0], 16'h5A3C});
    peer.send(PK_CTRL, PEER, 32'h0, 8'h00);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0);  // unmapped offset reads zero
    check(32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule // tb_top
